//--- design/spc_pkg.sv
// package: constants, types and helpers shared by the serial port core
package spc_pkg;
   // widths and depths
   localparam int DATA_W     = 8;
   localparam int BUS_W      = 16;
   localparam int FIFO_DEPTH = 8;
   localparam int LEN_W      = 3;
   localparam int DIV_W      = 7;
   localparam int PC_W       = 6;

   // port control fields: pin a in bits 2..0, pin b in bits 5..3
   localparam int FN_A  = 0;
   localparam int OUT_A = 1;
   localparam int DIR_A = 2;
   localparam int FN_B  = 3;
   localparam int OUT_B = 4;
   localparam int DIR_B = 5;

   // pin index in the synchronised read-back vector
   localparam int PIN_SIMO = 0;
   localparam int PIN_SLAVE_OUTPUT_LINE = 1;
   localparam int PIN_CLK  = 2;
   localparam int PIN_STE  = 3;
   localparam int NPIN     = 4;

   // half-period reload; least half period is this plus one clock; covers the two-stage input synchroniser
   localparam logic [7:0] HALF_BASE = 8'h04;
   // value after reset of every state bit and of the read buffer
   localparam logic [15:0] RBUF_RST = 16'h0000;

   typedef enum logic {SPC_IDLE, SPC_RUN} spc_state_type;

   // mask of the low len bits of a character
   function automatic logic [7:0] spc_mask(input logic [3:0] len);
      spc_mask = 8'((9'h001 << len) - 9'h001);
   endfunction : spc_mask

   // most significant bit of a character of len bits
   function automatic logic spc_msb(input logic [7:0] w, input logic [3:0] len);
      spc_msb = w[3'(len - 4'h1)];
   endfunction : spc_msb
endpackage : spc_pkg

//--- design/spc_core.sv
// file: fifo, link-clock slave shifter and top of the serial port core
`timescale 1ns/10ps

// =====================================================
// transmit fifo (depth must be a power of two)
module spc_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 8
) (
   input  wire logic             clk,
   input  wire logic             srst,
   input  wire logic             in_valid,
   output logic                  in_ready,
   input  wire logic [WIDTH-1:0] in_data,
   output logic                  out_valid,
   input  wire logic             out_ready,
   output logic      [WIDTH-1:0] out_data
);
   localparam int AW = $clog2(DEPTH);
   typedef struct packed {
      logic [DEPTH-1:0][WIDTH-1:0] mem;
      logic [AW-1:0]               wp;
      logic [AW-1:0]               rp;
      logic [AW:0]                 cnt;
   } spc_fifo_type;
   spc_fifo_type s_reg, s_next;
   logic wr, rd;

   // honest flags straight from the count
   assign in_ready  = s_reg.cnt != (AW+1)'(DEPTH);
   assign out_valid = s_reg.cnt != '0;
   assign out_data  = s_reg.mem[s_reg.rp];
   assign wr        = in_valid & in_ready;
   assign rd        = out_valid & out_ready;

   // pointer and count update
   always_comb begin
      s_next = s_reg;
      if (wr) begin
         s_next.mem[s_reg.wp] = in_data;
         s_next.wp = s_reg.wp + 1'b1;
      end
      if (rd) begin
         s_next.rp = s_reg.rp + 1'b1;
      end
      case ({wr, rd})
         2'b10: s_next.cnt = s_reg.cnt + 1'b1;
         2'b01: s_next.cnt = s_reg.cnt - 1'b1;
         default: s_next.cnt = s_reg.cnt;
      endcase
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         s_reg <= '0;
      end else begin
         s_reg <= s_next;
      end
   end
endmodule : spc_fifo

// =====================================================
// slave shifter on the network clock, rising edge = sample edge
module spc_link
   import spc_pkg::*;
(
   input  wire logic       lclk,
   input  wire logic       rst,
   input  wire logic       frame_rst,
   input  wire logic [3:0] len,
   input  wire logic [7:0] hold,
   input  wire logic       in_bit,
   output logic            out_bit,
   output logic [7:0]      rx_word,
   output logic            done_tgl,
   output logic            take_tgl
);
   logic [7:0] shift_reg;
   logic [2:0] cnt_reg;
   logic       outq_reg;
   logic [7:0] base;
   logic [7:0] shift_next;

   // first bit comes from the held word, later bits from the drive flop
   assign base       = (cnt_reg == 3'h0) ? hold : shift_reg;
   assign shift_next = {base[6:0], in_bit};
   assign out_bit    = (cnt_reg == 3'h0) ? spc_msb(hold, len) : outq_reg;

   // bit counter; an inactive strobe or master mode ends the frame
   always_ff @(posedge lclk or posedge frame_rst) begin
      if (frame_rst) begin
         cnt_reg <= 3'h0;
      end else if ({1'b0, cnt_reg} == len - 4'h1) begin
         cnt_reg <= 3'h0;
      end else begin
         cnt_reg <= cnt_reg + 3'h1;
      end
   end

   // sample edge: shift in, report take and done by toggles
   always_ff @(posedge lclk or posedge rst) begin
      if (rst) begin
         shift_reg <= 8'h00;
         rx_word   <= 8'h00;
         done_tgl  <= 1'b0;
         take_tgl  <= 1'b0;
      end else begin
         shift_reg <= shift_next;
         if (cnt_reg == 3'h0) begin
            take_tgl <= ~take_tgl;
         end
         if ({1'b0, cnt_reg} == len - 4'h1) begin
            rx_word  <= shift_next;
            done_tgl <= ~done_tgl;
         end
      end
   end

   // drive edge: next bit out, most significant first
   always_ff @(negedge lclk or posedge rst) begin
      if (rst) begin
         outq_reg <= 1'b0;
      end else begin
         outq_reg <= spc_msb(base, len);
      end
   end
endmodule : spc_link

// =====================================================
// top: master engine, slave hand-off, pins and status
module spc_core
   import spc_pkg::*;
(
   input  wire logic              ref_clk,
   input  wire logic              srst,
   input  wire logic              master_out_slave_in_pin_i,
   output logic                   master_out_slave_in_pin_o,
   output logic                   master_out_slave_in_pin_oe,
   input  wire logic              slave_out_master_in_pin_i,
   output logic                   slave_out_master_in_pin_o,
   output logic                   slave_out_master_in_pin_oe,
   input  wire logic              serial_shift_clock_pin_i,
   output logic                   serial_shift_clock_pin_o,
   output logic                   serial_shift_clock_pin_oe,
   input  wire logic              transmit_strobe_pin_i,
   output logic                   transmit_strobe_pin_o,
   output logic                   transmit_strobe_pin_oe,
   input  wire logic              master_mode,
   input  wire logic              clock_polarity,
   input  wire logic              clock_phase,
   input  wire logic              talk_enable,
   input  wire logic [LEN_W-1:0]  char_len_sel,
   input  wire logic [DIV_W-1:0]  baud_div,
   input  wire logic              transfer_irq_enable,
   input  wire logic [PC_W-1:0]   port_control_one,
   input  wire logic [PC_W-1:0]   port_control_two,
   input  wire logic [BUS_W-1:0]  tx_data,
   input  wire logic              tx_valid,
   output logic                   tx_ready,
   input  wire logic              flag_clear,
   output logic [BUS_W-1:0]       receive_buffer,
   output logic                   transfer_done_flag,
   output logic                   transfer_irq,
   output logic [NPIN-1:0]        gpio_in
);
   typedef struct packed {
      spc_state_type st;
      logic [7:0]    shift;
      logic          out_bit;
      logic          sck;
      logic [7:0]    div;
      logic [4:0]    edges;
      logic [3:0]    len;
      logic [7:0]    hold;
      logic          hold_full;
      logic [2:0]    tk;
      logic [2:0]    dn;
      logic [3:0]    p1;
      logic [3:0]    p2;
      logic          inv;
      logic          mst;
      logic          slave_ste;
      logic          flag;
      logic          irq;
      logic [15:0]   rbuf;
      logic          simo_o;
      logic          simo_oe;
      logic          slave_output_line_g;
      logic          slave_output_line_gp;
      logic          slave_output_line_oe;
      logic          sck_o;
      logic          sck_oe;
      logic          ste_o;
      logic          ste_oe;
   } spc_regs_type;
   spc_regs_type s, n;

   logic       f_valid, f_ready, done, mdone, sample, strobe_ok;
   logic [7:0] f_data, rx, rx_word;
   logic [3:0] len;
   logic [7:0] half;
   logic       link_bit, done_tgl, take_tgl, lclk, frame_rst;

   assign len  = {1'b0, char_len_sel} + 4'h1;
   assign half = {1'b0, baud_div} + HALF_BASE;
   assign f_ready = master_mode ? (s.st == SPC_IDLE) : !s.hold_full;

   // upper half of the written word is dropped here
   spc_fifo #(.WIDTH(DATA_W), .DEPTH(FIFO_DEPTH)) u_fifo (
      .clk       (ref_clk),
      .srst      (srst),
      .in_valid  (tx_valid),
      .in_ready  (tx_ready),
      .in_data   (tx_data[7:0]),
      .out_valid (f_valid),
      .out_ready (f_ready),
      .out_data  (f_data)
   );

   // sample edge made rising by polarity xor phase; config static between frames
   assign lclk      = serial_shift_clock_pin_i ^ s.inv;
   assign frame_rst = srst | s.mst | (s.slave_ste & transmit_strobe_pin_i);

   spc_link u_link (
      .lclk      (lclk),
      .rst       (srst),
      .frame_rst (frame_rst),
      .len       (s.len),
      .hold      (s.hold),
      .in_bit    (master_out_slave_in_pin_i),
      .out_bit   (link_bit),
      .rx_word   (rx_word),
      .done_tgl  (done_tgl),
      .take_tgl  (take_tgl)
   );

   // next state of everything in the system clock domain
   always_comb begin
      n         = s;
      done      = 1'b0;
      mdone     = 1'b0;
      sample    = 1'b0;
      rx        = 8'h00;
      n.p1      = {transmit_strobe_pin_i, serial_shift_clock_pin_i,
                   slave_out_master_in_pin_i, master_out_slave_in_pin_i};
      n.p2      = s.p1;
      n.tk      = {s.tk[1:0], take_tgl};
      n.dn      = {s.dn[1:0], done_tgl};
      n.inv     = clock_polarity ^ clock_phase;
      n.mst     = master_mode;
      n.slave_ste = !master_mode & port_control_one[FN_B];
      strobe_ok = !(s.slave_ste & s.p2[PIN_STE]);
      // master engine: one half period per clock edge
      case (s.st)
         SPC_IDLE: begin
            n.sck = clock_polarity;
            n.len = len;
            if (master_mode && f_valid) begin
               n.shift   = f_data;
               n.out_bit = spc_msb(f_data, len);
               n.edges   = 5'h00;
               n.div     = half;
               n.st      = SPC_RUN;
            end
         end
         SPC_RUN: begin
            if (s.div == 8'h00) begin
               n.div  = half;
               n.sck  = !s.sck;
               sample = s.edges[0] == clock_phase;
               if (sample) begin
                  n.shift = {s.shift[6:0], s.p2[PIN_SLAVE_OUTPUT_LINE]};
               end else begin
                  n.out_bit = spc_msb(s.shift, s.len);
               end
               if (s.edges == 5'({s.len, 1'b0} - 5'h01)) begin
                  mdone = 1'b1;
                  rx    = n.shift & spc_mask(s.len);
                  n.st  = SPC_IDLE;
               end else begin
                  n.edges = s.edges + 5'h01;
               end
            end else begin
               n.div = s.div - 8'h01;
            end
         end
         default: n.st = SPC_IDLE;
      endcase
      // slave hand-off: word waits in hold until the link takes it
      if (s.tk[1] ^ s.tk[2]) begin
         n.hold_full = 1'b0;
      end
      if (!master_mode && !s.hold_full && f_valid) begin
         n.hold      = f_data;
         n.hold_full = 1'b1;
      end
      // rx word is stable here only while the slave clock obeys the ratio
      done = mdone;
      if (!master_mode && (s.dn[1] ^ s.dn[2])) begin
         done = 1'b1;
         rx   = rx_word & spc_mask(s.len);
      end
      if (done) begin
         n.rbuf = {8'h00, rx};
      end
      // set wins over a clear in the same cycle
      n.flag = done | (s.flag & !flag_clear);
      n.irq  = s.flag & transfer_irq_enable;
      // pin functions
      n.simo_o  = port_control_two[FN_A] ? s.out_bit : port_control_two[OUT_A];
      n.simo_oe = port_control_two[FN_A] ? (master_mode & talk_enable)
                                         : port_control_two[DIR_A];
      n.slave_output_line_gp = !port_control_two[FN_B];
      n.slave_output_line_g  = port_control_two[OUT_B];
      n.slave_output_line_oe = port_control_two[FN_B] ? (!master_mode & talk_enable & strobe_ok)
                                         : port_control_two[DIR_B];
      n.sck_o   = port_control_one[FN_A] ? s.sck : port_control_one[OUT_A];
      n.sck_oe  = port_control_one[FN_A] ? master_mode : port_control_one[DIR_A];
      n.ste_o   = port_control_one[OUT_B];
      n.ste_oe  = (master_mode | !port_control_one[FN_B]) & port_control_one[DIR_B];
   end

   // all state zero at reset: idle, pins released, buffer RBUF_RST
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         s <= '0;
      end else begin
         s <= n;
      end
   end

   // outputs; slave data goes out from the link's held word for the first bit, then from its own drive flop
   assign master_out_slave_in_pin_o  = s.simo_o;
   assign master_out_slave_in_pin_oe = s.simo_oe;
   assign slave_out_master_in_pin_o  = s.slave_output_line_gp ? s.slave_output_line_g : link_bit;
   assign slave_out_master_in_pin_oe = s.slave_output_line_oe;
   assign serial_shift_clock_pin_o   = s.sck_o;
   assign serial_shift_clock_pin_oe  = s.sck_oe;
   assign transmit_strobe_pin_o      = s.ste_o;
   assign transmit_strobe_pin_oe     = s.ste_oe;
   assign receive_buffer             = s.rbuf;
   assign transfer_done_flag         = s.flag;
   assign transfer_irq               = s.irq;
   assign gpio_in                    = s.p2;

   // =====================================================
   // checks
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (srst);

   sequence m_start_s;
      s.st == SPC_IDLE ##1 s.st == SPC_RUN;
   endsequence
   sequence m_end_s;
      s.st == SPC_RUN ##1 s.st == SPC_IDLE;
   endsequence

   char_count_a: assert property (
      mdone |-> s.edges == 5'({s.len, 1'b0} - 5'h01) && s.div == 8'h00)
      else $error("transfer ended on a wrong edge count");
   first_half_a: assert property (
      m_start_s |-> $stable(s.sck) [*3])
      else $error("clock moved before the first half period");
   msb_first_a: assert property (
      m_start_s |-> s.out_bit == spc_msb(s.shift, s.len))
      else $error("first bit out is not the top bit");
   end_flag_a: assert property (
      m_end_s |-> s.flag)
      else $error("done flag missing at end of transfer");
   buf_just_a: assert property (
      m_end_s |-> (s.rbuf[7:0] & ~spc_mask(s.len)) == 8'h00)
      else $error("received character not right-justified");
   irq_gate_a: assert property (
      1'b1 |=> s.irq == $past(s.flag & transfer_irq_enable))
      else $error("interrupt does not follow flag and enable");
   set_wins_a: assert property (
      done && flag_clear |=> s.flag)
      else $error("clear beat a new completion");
   upper_zero_a: assert property (
      s.rbuf[15:8] == 8'h00)
      else $error("upper read byte not zero");
   slave_output_line_float_a: assert property (
      s.slave_ste && s.p2[PIN_STE] |=> !s.slave_output_line_oe)
      else $error("slave output driven while strobe inactive");
   free_slave_a: assert property (
      !master_mode && !s.slave_ste && talk_enable && port_control_two[FN_B] |=> s.slave_output_line_oe)
      else $error("free slave did not drive its output");
   ste_gpio_a: assert property (
      master_mode |=> s.ste_oe == $past(port_control_one[DIR_B]))
      else $error("strobe pin not general-purpose in master mode");
   sck_drive_a: assert property (
      master_mode && port_control_one[FN_A] |=> s.sck_oe && s.sck_o == $past(s.sck))
      else $error("master does not drive the serial clock");
endmodule : spc_core

//--- tb/spc_peer.sv
// far-side party of the serial port: network master or network slave
`timescale 1ns/10ps

// =====================================================
// behavioural peer; the testbench resolves every wire from the design's enable, else the peer drives it
module spc_peer (
   input  wire logic pol,
   input  wire logic pha,
   input  wire logic sclk,
   input  wire logic mosi,
   input  wire logic miso,
   output logic      sclk_drv,
   output logic      mosi_drv,
   output logic      miso_drv,
   output logic      strobe_drv_n
);
   logic ph;
   wire logic s_edge = sclk ^ pol ^ pha;

   // the clock stands at its idle level between frames
   assign sclk_drv = pol ^ ph;

   initial begin
      ph = 1'b0;
      mosi_drv = 1'b0;
      miso_drv = 1'b0;
      strobe_drv_n = 1'b1;
   end

   // slave role: drive on one edge, capture on the other, msb first
   task automatic slave_frame(input logic [7:0] w, input int n, output logic [7:0] got);
      got = 8'h00;
      miso_drv = w[n-1];
      for (int i = 0; i < n; i++) begin
         if (pha || i > 0) begin
            @(negedge s_edge);
            miso_drv = w[n-1-i];
         end
         @(posedge s_edge);
         got = {got[6:0], mosi};
      end
      if (!pha) @(negedge s_edge);
      miso_drv = ~miso_drv; // released line must not keep the last bit
   endtask : slave_frame

   // master role: the peer makes every clock edge of the frame
   task automatic master_frame(input logic [7:0] w, input int n, input logic stb,
                               output logic [7:0] got);
      int d;
      got = 8'h00;
      d = 0;
      if (stb) strobe_drv_n = 1'b0;
      if (!pha) begin
         mosi_drv = w[n-1];
         d = 1;
      end
      #80;
      repeat (2 * n) begin
         miso_drv = ~miso_drv; // undriven line keeps changing
         if (s_edge == 1'b0) begin
            got = {got[6:0], miso};
            ph = ~ph;
         end else begin
            ph = ~ph;
            mosi_drv = (d < n) ? w[n-1-d] : ~mosi_drv;
            d++;
         end
         #80; // 160 ns period, far below an eighth of ref_clk
      end
      strobe_drv_n = 1'b1;
   endtask : master_frame
endmodule : spc_peer

//--- tb/spc_core_test.sv
// self-checking bench for the serial port core against a far-side peer
`timescale 1ns/10ps

// =====================================================
// bench top
module spi_port_core_test
   import spc_pkg::*;
   ;
   logic              ref_clk = 1'b0;
   logic              srst = 1'b1;
   logic              master_mode, clock_polarity, clock_phase, talk_enable;
   logic              transfer_irq_enable, tx_valid, flag_clear;
   logic [LEN_W-1:0]  char_len_sel;
   logic [DIV_W-1:0]  baud_div;
   logic [PC_W-1:0]   pc1, pc2;
   logic [BUS_W-1:0]  tx_data, receive_buffer;
   logic              mosi_o, mosi_oe, miso_o, miso_oe, sclk_o, sclk_oe, stb_o, stb_oe;
   logic              p_sclk, p_mosi, p_miso, p_stb_n;
   logic              tx_ready, transfer_done_flag, transfer_irq, r;
   logic [NPIN-1:0]   gpio;
   logic [7:0]        s, got, mk;
   logic [15:0]       e;
   logic [15:0]       q[$];
   int                n, edges, num_errors = 0, compares = 0;

   // each wire takes the design value while it drives, else the peer's
   wire logic sclk_w = sclk_oe ? sclk_o : p_sclk;
   wire logic mosi_w = mosi_oe ? mosi_o : p_mosi;
   wire logic miso_w = miso_oe ? miso_o : p_miso;
   wire logic stb_w  = stb_oe ? stb_o : p_stb_n;

   spc_core i_spc_core (
      .ref_clk(ref_clk), .srst(srst),
      .master_out_slave_in_pin_i(mosi_w), .master_out_slave_in_pin_o(mosi_o),
      .master_out_slave_in_pin_oe(mosi_oe), .slave_out_master_in_pin_i(miso_w),
      .slave_out_master_in_pin_o(miso_o), .slave_out_master_in_pin_oe(miso_oe),
      .serial_shift_clock_pin_i(sclk_w), .serial_shift_clock_pin_o(sclk_o),
      .serial_shift_clock_pin_oe(sclk_oe), .transmit_strobe_pin_i(stb_w),
      .transmit_strobe_pin_o(stb_o), .transmit_strobe_pin_oe(stb_oe),
      .master_mode(master_mode), .clock_polarity(clock_polarity),
      .clock_phase(clock_phase), .talk_enable(talk_enable), .char_len_sel(char_len_sel),
      .baud_div(baud_div), .transfer_irq_enable(transfer_irq_enable),
      .port_control_one(pc1), .port_control_two(pc2), .tx_data(tx_data),
      .tx_valid(tx_valid), .tx_ready(tx_ready), .flag_clear(flag_clear),
      .receive_buffer(receive_buffer), .transfer_done_flag(transfer_done_flag),
      .transfer_irq(transfer_irq), .gpio_in(gpio)
   );

   spc_peer i_spc_peer (
      .pol(clock_polarity), .pha(clock_phase), .sclk(sclk_w), .mosi(mosi_w),
      .miso(miso_w), .sclk_drv(p_sclk), .mosi_drv(p_mosi), .miso_drv(p_miso),
      .strobe_drv_n(p_stb_n)
   );

   // 200 MHz system clock
   initial begin
      forever #2.5 ref_clk = ~ref_clk;
   end

   // edges made by the design while it is master
   always @(sclk_w) if (master_mode) edges++;

   // =====================================================
   // shared tasks
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      compares++;
      if (seen !== exp) begin
         num_errors++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check

   task automatic finish_test();
      $display("compares %0d num_errors %0d", compares, num_errors);
      if (num_errors == 0 && compares > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask : finish_test

   task automatic tick(input int c);
      repeat (c) @(posedge ref_clk);
      #1;
   endtask : tick

   // one word into the fifo, held until taken; the model queue follows
   task automatic push(input logic [15:0] d);
      tick(1);
      tx_data = d;
      tx_valid = 1'b1;
      while (tx_ready !== 1'b1) tick(1);
      q.push_back(d);
      tick(1);
      tx_valid = 1'b0;
   endtask : push

   // bounded wait for completion, then flag clear
   task automatic done_and_clear();
      int k;
      k = 0;
      while (transfer_done_flag !== 1'b1 && k < 20000) begin
         tick(1);
         k++;
      end
      check(16'(k < 20000), 16'h0001);
      tick(1);
      check(16'(transfer_irq), 16'(transfer_irq_enable));
      flag_clear = 1'b1;
      tick(1);
      flag_clear = 1'b0;
      tick(1);
      check(16'(transfer_done_flag), 16'h0000);
   endtask : done_and_clear

   // slave frame from the peer; fifo head must come out, peer word must land
   task automatic slave_check(input logic stb);
      s = 8'($urandom);
      e = q.pop_front();
      i_spc_peer.master_frame(s, n, stb, got);
      check(16'(got & mk), 16'(e[7:0] & mk));
      done_and_clear();
      check(receive_buffer, {8'h00, s & mk});
   endtask : slave_check

   // =====================================================
   // main sequence
   initial begin
      void'($urandom(87446));
      {master_mode, clock_polarity, clock_phase, transfer_irq_enable} = 4'h0;
      {talk_enable, tx_valid, flag_clear, char_len_sel, baud_div} = '0;
      talk_enable = 1'b1;
      {pc1, pc2, tx_data} = '0;
      tick(20);
      check(16'({sclk_oe, mosi_oe, miso_oe, stb_oe, transfer_done_flag}), 16'h0000);
      check(receive_buffer, RBUF_RST);
      srst = 1'b0;
      tick(1);
      check(16'(tx_ready), 16'h0001);
      // both data pins as driven general-purpose outputs, level high
      pc2 = 6'h36;
      tick(2);
      check(16'({mosi_oe, mosi_o, miso_oe, miso_o}), 16'h000f);
      pc2 = 6'h09; // both data pins in serial function
      // master: every phase and polarity, random length and rate
      for (int m = 0; m < 8; m++) begin
         r = 1'($urandom);
         master_mode = 1'b1;
         {transfer_irq_enable, clock_polarity, clock_phase} = 3'(m);
         baud_div = 7'($urandom_range(0, 15));
         char_len_sel = 3'($urandom);
         pc1 = {1'b1, r, 1'b1, 3'b001}; // strobe function on, still gpio
         n = char_len_sel + 1;
         mk = 8'((9'h001 << n) - 9'h001);
         s = 8'($urandom);
         tick(3);
         edges = 0;
         fork
            push({8'($urandom), 8'($urandom)});
            i_spc_peer.slave_frame(s, n, got);
         join
         e = q.pop_front();
         check(16'(got & mk), 16'(e[7:0] & mk));
         done_and_clear();
         check(receive_buffer, {8'h00, s & mk});
         check(16'(edges), 16'(2 * n));
         check(16'({sclk_oe, sclk_w}), 16'({1'b1, clock_polarity}));
         check(16'({stb_oe, stb_o}), 16'({1'b1, r}));
         check(16'(gpio[PIN_STE:PIN_CLK]), 16'({r, clock_polarity}));
      end
      // slave with strobe: first mode fills hold word and fifo to refusal
      master_mode = 1'b0;
      pc1 = 6'h09;
      for (int m = 0; m < 4; m++) begin
         {clock_polarity, clock_phase} = 2'(m);
         char_len_sel = 3'($urandom);
         n = char_len_sel + 1;
         mk = 8'((9'h001 << n) - 9'h001);
         tick(4);
         check(16'(miso_oe), 16'h0000);
         // the slave hold register takes one word ahead of the fifo
         repeat ((m == 0) ? FIFO_DEPTH + 1 : 2) push({8'($urandom), 8'($urandom)});
         tick(2);
         check(16'(tx_ready), 16'((m == 0) ? 0 : 1));
         while (q.size() > 0) slave_check(1'b1);
         check(16'(miso_oe), 16'h0000);
      end
      check(16'(tx_ready), 16'h0001);
      // slave with strobe function off: strobe stays high, shifting still runs
      pc1 = 6'h01;
      tick(2);
      push({8'($urandom), 8'($urandom)});
      slave_check(1'b0);
      check(16'(miso_oe), 16'h0001);
      // talk off floats the slave output even without a strobe
      talk_enable = 1'b0;
      tick(2);
      check(16'(miso_oe), 16'h0000);
      finish_test();
   end

   // watchdog
   initial begin
      #300000;
      num_errors++;
      finish_test();
   end
endmodule : spi_port_core_test
